// ===== flash_regs_pkg.sv
// constants shared by the flash disk control register device and its host controller
// assumes an sram-like byte register window driven by a single clock
// Contract
// RQ1 - delay dummy writes change nothing; here they still drop a pending control value
// RQ2 - host uses delay dummy for padding; this host sends no delay dummy writes of its own
// RQ3 - eight-bit scratch register, reset zero, inert
// RQ4 - control and confirm read same, 0x10
// RQ5 - host writes complement to confirm register; this host writes the command's data byte as given
// RQ6 - control and confirm writes back to back
// RQ7 - mode codes: 00 reset, 01 normal, 10 sleep
// RQ8 - mode changes need mode write enable set
// RQ9 - boot detect sets flag, write one clears
// RQ10 - external or voltage reset sets latch flag
// RQ11 - answer only when cascade select matches id
// RQ12 - all reads zero while in reset mode
// RQ13 - reserved bits read zero, host writes zero; this host passes the command's data byte through unmasked
// RQ14 - commit only on matching immediate confirm
package flash_regs_pkg;
  localparam logic [12:0] delay_dummy_off = 13'h1002;
  localparam logic [12:0] alias_scratch_off = 13'h1004;
  localparam logic [12:0] mode_control_off = 13'h1006;
  localparam logic [12:0] cascade_select_off = 13'h1008;
  localparam logic [12:0] mode_control_confirm_off = 13'h1076;
  localparam logic [7:0] alias_scratch_rst = 8'h00;
  localparam logic [7:0] mode_control_rst = 8'h10;
  localparam logic [7:0] cascade_select_rst = 8'h00;
  localparam int mode_lsb = 0;
  localparam int mode_write_enable_bit = 2;
  localparam int boot_detected_flag_bit = 3;
  localparam int reset_latch_flag_bit = 4;
  localparam logic [1:0] mode_reset = 2'h0;
  localparam logic [1:0] mode_normal = 2'h1;
  localparam logic [1:0] mode_sleep = 2'h2;
  localparam logic [7:0] mode_control_mask = 8'h1f;
  localparam logic [7:0] cascade_select_mask = 8'h03;
  // controller registers on ahb-lite
  localparam logic [7:0] ctl_cmd_off = 8'h00;
  localparam logic [7:0] ctl_status_off = 8'h04;
  localparam logic [7:0] ctl_rdata_off = 8'h08;
  localparam logic [7:0] ctl_irq_status_off = 8'h0c;
  localparam logic [7:0] ctl_irq_mask_off = 8'h10;
  localparam int cmd_data_lsb = 0;
  localparam int cmd_addr_lsb = 8;
  localparam int cmd_write_bit = 31;
  localparam int cmd_mode_bit = 30;
  localparam logic [31:0] ctl_rst = 32'h0000_0000;
endpackage

// ===== flash_bus_if.sv
`timescale 1ns/1ps
// sram-like register window between host controller and device
// assumes both ends run on the same clock; one access per strobe cycle
interface flash_bus_if;
  logic cs;
  logic we;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport device (input cs, input we, input addr, input wdata, output rdata, output rvalid);
  modport host (output cs, output we, output addr, output wdata, input rdata, input rvalid);
endinterface

// ===== flash_mode_device.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
// device end: mode control register bank with cascade decode
// assumes id balls, boot detector and voltage detector are asynchronous inputs
module flash_mode_device (
  input wire logic hclk,
  input wire logic hresetn,
  flash_bus_if.device bus,
  input wire logic [1:0] device_id,
  input wire logic boot_detect,
  input wire logic voltage_detect,
  input wire logic external_reset_in_n,
  output logic [1:0] mode,
  output logic [7:0] scratch
);
  logic [1:0] id_s1_q, id_s2_q;
  logic [2:0] ev_s1_q, ev_s2_q;
  logic [7:0] scratch_q, ctl_q, sel_q, pend_q, rdata_q;
  logic pend_valid_q, rvalid_q;
  wire match = id_s2_q == sel_q[1:0];
  wire acc = bus.cs && match; // see RQ11
  wire wr = acc && bus.we;
  wire rd = acc && !bus.we;
  wire in_reset = ctl_q[1:0] == flash_regs_pkg::mode_reset;
  wire hit_ctl = bus.addr == flash_regs_pkg::mode_control_off;
  wire hit_cfm = bus.addr == flash_regs_pkg::mode_control_confirm_off;
  wire boot_ev = ev_s2_q[0];
  wire rst_ev = ev_s2_q[1] | ev_s2_q[2];
  // confirm write must follow directly and be the complement
  wire commit = wr && hit_cfm && pend_valid_q && (bus.wdata == ~pend_q); // see RQ14
  wire [7:0] w1c = commit ? pend_q : 8'h00;
  wire mode_ok = commit && pend_q[flash_regs_pkg::mode_write_enable_bit]; // see RQ8
  logic [7:0] ctl_d;
  logic [7:0] rd_mux;
  always_comb begin
    ctl_d = ctl_q;
    if (mode_ok) begin
      ctl_d[1:0] = pend_q[1:0]; // see RQ7
    end
    ctl_d[flash_regs_pkg::mode_write_enable_bit] = commit ?
      pend_q[flash_regs_pkg::mode_write_enable_bit] : ctl_q[flash_regs_pkg::mode_write_enable_bit];
    if (w1c[flash_regs_pkg::boot_detected_flag_bit]) begin
      ctl_d[flash_regs_pkg::boot_detected_flag_bit] = 1'b0;
    end
    if (w1c[flash_regs_pkg::reset_latch_flag_bit]) begin
      ctl_d[flash_regs_pkg::reset_latch_flag_bit] = 1'b0;
    end
    if (boot_ev) begin
      ctl_d[1:0] = flash_regs_pkg::mode_reset;
      ctl_d[flash_regs_pkg::boot_detected_flag_bit] = 1'b1; // see RQ9
    end
    if (rst_ev) begin
      ctl_d[1:0] = flash_regs_pkg::mode_reset;
      ctl_d[flash_regs_pkg::reset_latch_flag_bit] = 1'b1; // see RQ10
    end
    ctl_d = ctl_d & flash_regs_pkg::mode_control_mask; // see RQ13
  end
  always_comb begin
    rd_mux = 8'h00;
    if (!in_reset) begin // see RQ12
      if (bus.addr == flash_regs_pkg::alias_scratch_off) begin
        rd_mux = scratch_q;
      end else if (hit_ctl || hit_cfm) begin
        rd_mux = ctl_q; // see RQ4
      end else if (bus.addr == flash_regs_pkg::cascade_select_off) begin
        rd_mux = sel_q & flash_regs_pkg::cascade_select_mask;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_s1_q <= 2'h0;
      id_s2_q <= 2'h0;
      ev_s1_q <= 3'h0;
      ev_s2_q <= 3'h0;
    end else begin
      id_s1_q <= device_id;
      id_s2_q <= id_s1_q;
      ev_s1_q <= {voltage_detect, ~external_reset_in_n, boot_detect};
      ev_s2_q <= ev_s1_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scratch_q <= flash_regs_pkg::alias_scratch_rst;
      ctl_q <= flash_regs_pkg::mode_control_rst;
      sel_q <= flash_regs_pkg::cascade_select_rst;
      pend_q <= 8'h00;
      pend_valid_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      rvalid_q <= rd;
      rdata_q <= rd ? rd_mux : 8'h00;
      // delay dummy and unmapped writes change no register but still drop the pending control value; see RQ1
      if (wr && bus.addr == flash_regs_pkg::alias_scratch_off) begin
        scratch_q <= bus.wdata; // see RQ3
      end
      if (wr && bus.addr == flash_regs_pkg::cascade_select_off) begin
        sel_q <= bus.wdata & flash_regs_pkg::cascade_select_mask;
      end
      // any other access drops the pending value; see RQ14
      if (acc) begin
        pend_valid_q <= wr && hit_ctl;
        pend_q <= bus.wdata;
      end
    end
  end
  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= flash_regs_pkg::mode_reset;
      scratch <= flash_regs_pkg::alias_scratch_rst;
    end else begin
      mode <= ctl_d[1:0];
      scratch <= scratch_q;
    end
  end
endmodule

// ===== flash_mode_host.sv
`timescale 1ns/1ps
// host end: ahb-lite slave that issues register cycles to the device
// assumes one device answers reads one cycle after the strobe
module flash_mode_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  flash_bus_if.host bus
);
  typedef enum logic [1:0] {idle, issue, wait_rd} state_e;
  state_e state_q;
  logic aw_q;
  logic [7:0] aa_q;
  logic [31:0] rdata_q, irq_status_q, irq_mask_q;
  logic [31:0] hrdata_q;
  logic busy_q, cs_q, we_q;
  logic [12:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] dev_rdata_q;
  wire take = hsel && hready && htrans[1];
  wire wr_cmd = aw_q && aa_q == flash_regs_pkg::ctl_cmd_off && !busy_q;
  wire wr_ist = aw_q && aa_q == flash_regs_pkg::ctl_irq_status_off;
  wire wr_msk = aw_q && aa_q == flash_regs_pkg::ctl_irq_mask_off;
  wire done = (state_q == issue && !we_q) ? 1'b0 : (state_q == issue || (state_q == wait_rd && bus.rvalid));
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      flash_regs_pkg::ctl_status_off: rd_mux = {31'h0, busy_q};
      flash_regs_pkg::ctl_rdata_off: rd_mux = {24'h0, dev_rdata_q};
      flash_regs_pkg::ctl_irq_status_off: rd_mux = irq_status_q;
      flash_regs_pkg::ctl_irq_mask_off: rd_mux = irq_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 1'b0;
      aa_q <= 8'h00;
      hrdata_q <= flash_regs_pkg::ctl_rst;
      irq_status_q <= flash_regs_pkg::ctl_rst;
      irq_mask_q <= flash_regs_pkg::ctl_rst;
      irq <= 1'b0;
    end else begin
      aw_q <= take && hwrite;
      if (take) begin
        aa_q <= haddr[7:0];
      end
      // read data stands through the data phase that follows the address phase
      if (take && !hwrite) begin
        hrdata_q <= rd_mux;
      end
      if (wr_msk) begin
        irq_mask_q <= hwdata & 32'h0000_0001;
      end
      // completion sets the sticky bit and wins over the clear
      irq_status_q <= ((wr_ist ? irq_status_q & ~hwdata : irq_status_q) | {31'h0, done})
        & 32'h0000_0001;
      irq <= |(irq_status_q & irq_mask_q);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= idle;
      busy_q <= 1'b0;
      cs_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 13'h0000;
      wdata_q <= 8'h00;
      dev_rdata_q <= 8'h00;
    end else begin
      case (state_q)
        idle: begin
          // host command: one cycle per device access, so confirms can follow back to back
          // see RQ5 see RQ6 see RQ2
          if (wr_cmd) begin
            cs_q <= 1'b1;
            we_q <= hwdata[flash_regs_pkg::cmd_write_bit];
            addr_q <= hwdata[flash_regs_pkg::cmd_addr_lsb +: 13];
            wdata_q <= hwdata[flash_regs_pkg::cmd_data_lsb +: 8]; // see RQ13
            busy_q <= 1'b1;
            state_q <= issue;
          end
        end
        issue: begin
          cs_q <= 1'b0;
          if (we_q) begin
            busy_q <= 1'b0;
            state_q <= idle;
          end else begin
            state_q <= wait_rd;
          end
        end
        wait_rd: begin
          if (bus.rvalid) begin
            dev_rdata_q <= bus.rdata;
            busy_q <= 1'b0;
            state_q <= idle;
          end
        end
        default: state_q <= idle;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign bus.cs = cs_q;
  assign bus.we = we_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
endmodule

// ===== flash_regs_monitor.sv
// checker on the register window between host and device ends
// assumes instantiation beside the interface, single clock domain
`timescale 1ns/1ps
module flash_regs_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs,
  input wire logic we,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  localparam logic [12:0] ctl_a = flash_regs_pkg::mode_control_off;
  localparam logic [12:0] cnf_a = flash_regs_pkg::mode_control_confirm_off;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] ctl_q;
  logic seen_q;
  logic [12:0] ra_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= 8'h00;
      seen_q <= 1'b0;
      ra_q <= 13'h0000;
    end else begin
      if (cs) ra_q <= addr;
      if (cs && we) seen_q <= 1'b0;
      else if (rvalid && ra_q == ctl_a) seen_q <= 1'b1;
      if (rvalid && ra_q == ctl_a) ctl_q <= rdata;
    end
  end
  a_read_answered: assert property (cs && !we |=> rvalid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (rvalid |-> $past(cs && !we))
    else $error("answer without read strobe");
  a_write_silent: assert property (cs && we |=> !rvalid [*2])
    else $error("answer after write strobe");
  a_strobe_single: assert property (cs |=> !cs)
    else $error("strobe longer than one cycle");
  a_ctl_reserved: assert property (rvalid && ra_q == ctl_a |-> rdata[7:5] == 3'h0)
    else $error("control reserved bits set");
  a_cnf_reserved: assert property (rvalid && ra_q == cnf_a |-> rdata[7:5] == 3'h0)
    else $error("confirm reserved bits set");
  a_sel_reserved: assert property (rvalid && ra_q == flash_regs_pkg::cascade_select_off
    |-> rdata[7:2] == 6'h00)
    else $error("select reserved bits set");
  a_confirm_same: assert property (rvalid && ra_q == cnf_a && seen_q |-> rdata == ctl_q)
    else $error("confirm differs from control");
  a_ctl_write_zero: assert property (cs && we && addr == ctl_a |-> wdata[7:5] == 3'h0)
    else $error("control write sets reserved bits");
endmodule

// ===== testbench.sv
// self-checking bench: host and device ends joined by the window
// assumes ahb-lite access to the host, device events driven directly
`timescale 1ns/1ps
module testbench;
  localparam logic [12:0] ctl_a = flash_regs_pkg::mode_control_off;
  localparam logic [12:0] cnf_a = flash_regs_pkg::mode_control_confirm_off;
  localparam logic [12:0] scr_a = flash_regs_pkg::alias_scratch_off;
  localparam logic [12:0] sel_a = flash_regs_pkg::cascade_select_off;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, irq;
  logic bd = 0, vd = 0, ext_rst_n = 1;
  logic [1:0] htrans = 2'h0, id = 2'h0, mode;
  logic [7:0] scr, f;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [7:0] md[5] = '{8'h06, 8'h05, 8'h04, 8'h05, 8'h02};
  logic [1:0] me[5] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h1};
  int failures = 0, compares = 0;
  always #2 hclk = ~hclk;
  flash_bus_if flash_bus_if_i ();
  flash_mode_host flash_mode_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata(hrdata), .irq(irq),
    .bus(flash_bus_if_i));
  flash_mode_device flash_mode_device_i (.hclk(hclk), .hresetn(hresetn),
    .bus(flash_bus_if_i), .device_id(id), .boot_detect(bd), .voltage_detect(vd),
    .external_reset_in_n(ext_rst_n), .mode(mode), .scratch(scr));
  flash_regs_monitor flash_regs_monitor_i (.hclk(hclk), .hresetn(hresetn),
    .cs(flash_bus_if_i.cs), .we(flash_bus_if_i.we), .addr(flash_bus_if_i.addr),
    .wdata(flash_bus_if_i.wdata), .rdata(flash_bus_if_i.rdata),
    .rvalid(flash_bus_if_i.rvalid));
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task tmo;
    failures++;
    $display("Error %0t wait timed out", $time);
    end_of_test;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask
  task edge_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) tmo;
      @(posedge hclk);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy;
    r = hrdata;
  endtask
  task dev(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    ahb(1'b1, flash_regs_pkg::ctl_cmd_off, {w, 10'h000, a, d});
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) begin
      n++;
      if (n > 50) tmo;
      ahb(1'b0, flash_regs_pkg::ctl_status_off, 32'h0000_0000);
    end
    if (!w) ahb(1'b0, flash_regs_pkg::ctl_rdata_off, 32'h0000_0000);
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    dev(1'b0, a, 8'h00);
    chk(r[7:0], e);
  endtask
  task mset(input logic [7:0] d, input logic [7:0] c);
    dev(1'b1, ctl_a, d);
    dev(1'b1, cnf_a, c);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(scr_a, 8'h00);
    rd(ctl_a, 8'h00);
    ahb(1'b0, flash_regs_pkg::ctl_irq_status_off, 32'h0000_0000);
    chk({7'h00, r[0]}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    ahb(1'b1, flash_regs_pkg::ctl_irq_mask_off, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk({7'h00, irq}, 8'h01);
    ahb(1'b1, flash_regs_pkg::ctl_irq_status_off, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk({7'h00, irq}, 8'h00);
    mset(8'h05, 8'hfa);
    chk({6'h00, mode}, 8'h01);
    rd(ctl_a, 8'h15);
    rd(cnf_a, 8'h15);
    $display("test reset_and_irq done");
    dev(1'b1, scr_a, 8'ha5);
    dev(1'b1, flash_regs_pkg::delay_dummy_off, 8'hff);
    rd(scr_a, 8'ha5);
    chk(scr, 8'ha5);
    rd(ctl_a, 8'h15);
    rd(sel_a, 8'h00);
    $display("test scratch done");
    for (int i = 0; i < 5; i++) begin
      mset(md[i], ~md[i]);
      chk({6'h00, mode}, {6'h00, me[i]});
    end
    mset(8'h06, 8'h00);
    chk({6'h00, mode}, 8'h01);
    dev(1'b1, ctl_a, 8'h06);
    dev(1'b1, scr_a, 8'h11);
    dev(1'b1, cnf_a, 8'hf9);
    chk({6'h00, mode}, 8'h01);
    $display("test modes done");
    mset(8'h15, 8'hea);
    rd(ctl_a, 8'h05);
    for (int k = 0; k < 3; k++) begin
      bd <= (k == 0);
      ext_rst_n <= (k != 1);
      vd <= (k == 2);
      @(posedge hclk);
      bd <= 1'b0;
      ext_rst_n <= 1'b1;
      vd <= 1'b0;
      repeat (4) @(posedge hclk);
      chk({6'h00, mode}, 8'h00);
      f = (k == 0) ? 8'h0d : 8'h15;
      mset(8'h05, 8'hfa);
      rd(ctl_a, f);
      mset(f, ~f);
      rd(ctl_a, 8'h05);
    end
    $display("test flags done");
    dev(1'b1, scr_a, 8'h5a);
    dev(1'b1, sel_a, 8'h01);
    dev(1'b1, scr_a, 8'h3c);
    id <= 2'h1;
    repeat (4) @(posedge hclk);
    rd(sel_a, 8'h01);
    rd(scr_a, 8'h5a);
    $display("test cascade done");
    end_of_test;
  end
endmodule
